// [design/citd_pkg.sv]
// package of opcode fields, lengths and decoder types for the arithmetic decoder
package citd_pkg;
    localparam logic [3:0] OPC_ADD       = 4'h2;
    localparam logic [3:0] OPC_ADD_WITH_CARRY      = 4'h3;
    localparam logic [3:0] OPC_SUBTRACT_WITH_BORROW      = 4'h9;
    localparam int         OPC_HI_POS    = 4;
    localparam logic [2:0] LEN_ONE       = 3'h1;
    localparam logic [2:0] LEN_TWO       = 3'h2;
    localparam logic [2:0] LEN_THREE     = 3'h3;
    localparam logic [7:0] PSW_RESET     = 8'h00;
    localparam logic [7:0] ACC_RESET     = 8'h00;
    localparam logic [15:0] PC_RESET     = 16'h0000;
    localparam int         PSW_CY        = 7;
    localparam int         PSW_AC        = 6;
    localparam int         PSW_OV        = 2;
    localparam int         PSW_P         = 0;

    typedef enum logic [2:0] {
        CITD_SRC_REG,
        CITD_SRC_DIR,
        CITD_SRC_IND,
        CITD_SRC_IMM,
        CITD_SRC_NONE
    } citd_src_type;

    typedef enum logic [1:0] {
        CITD_OP_ADD,
        CITD_OP_ADD_WITH_CARRY,
        CITD_OP_SUBTRACT_WITH_BORROW,
        CITD_OP_OTHER
    } citd_op_type;

    typedef struct packed {
        citd_op_type  op;
        citd_src_type src;
        logic [2:0]   len;
        logic         is_branch;
        logic [2:0]   reg_sel;
    } citd_dec_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic       indirect;
    } citd_rd_req_type;
endpackage : citd_pkg

// [design/citd_opnd_ram.sv]
// small internal data ram holding operand bytes, registered read
`timescale 1ns/10ps
`default_nettype none
module citd_opnd_ram #(
    parameter int DEPTH = 256
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_we,
    input  wire logic [7:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [7:0] i_raddr,
    output var  logic [7:0] o_rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        o_rdata <= mem[i_raddr];
    end
endmodule // citd_opnd_ram
`default_nettype wire

// [design/citd_core.sv]
// arithmetic instruction decoder and timing sequencer of the core
// Operation
// - all timing counted in system clocks, no machine cycles
// - most instructions take as many clocks as program bytes
// - conditional branch not taken finishes one clock sooner than taken
// - add: register, direct, indirect, immediate; lengths 1,2,1,2
// - add_with_carry adds operand plus carry, same forms and lengths
// - subtract_with_borrow subtracts operand and borrow; lengths 1,2,1,2
// - standard opcodes and status flag effects; the indirect form's operand is R0/R1 itself, not the byte it points to
`timescale 1ns/10ps
`default_nettype none
module citd_core #(
    parameter int RAM_DEPTH = 256
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_b,
    input  wire logic [7:0]  i_code_byte,
    input  wire logic        i_branch_cond,
    input  wire logic        i_ram_we,
    input  wire logic [7:0]  i_ram_waddr,
    input  wire logic [7:0]  i_ram_wdata,
    output var  logic [15:0] o_code_addr,
    output var  logic [7:0]  o_acc,
    output var  logic [7:0]  o_psw,
    output logic             o_instr_done
);
    // opcode decode, standard encoding: low nibble picks operand form
    function automatic citd_pkg::citd_dec_type decode(input logic [7:0] opc);
        citd_pkg::citd_dec_type d;
        d = '{op: citd_pkg::CITD_OP_OTHER, src: citd_pkg::CITD_SRC_NONE,
              len: citd_pkg::LEN_ONE, is_branch: 1'b0, reg_sel: opc[2:0]};
        unique case (opc[7:citd_pkg::OPC_HI_POS])
            citd_pkg::OPC_ADD:  d.op = citd_pkg::CITD_OP_ADD;
            citd_pkg::OPC_ADD_WITH_CARRY: d.op = citd_pkg::CITD_OP_ADD_WITH_CARRY;
            citd_pkg::OPC_SUBTRACT_WITH_BORROW: d.op = citd_pkg::CITD_OP_SUBTRACT_WITH_BORROW;
            default:            d.op = citd_pkg::CITD_OP_OTHER;
        endcase
        if (d.op != citd_pkg::CITD_OP_OTHER) begin
            if (opc[3]) begin
                d.src = citd_pkg::CITD_SRC_REG;
                d.len = citd_pkg::LEN_ONE;
            end else if (opc[3:1] == 3'h3) begin
                d.src = citd_pkg::CITD_SRC_IND;
                d.len = citd_pkg::LEN_ONE;
            end else if (opc[3:0] == 4'h5) begin
                d.src = citd_pkg::CITD_SRC_DIR;
                d.len = citd_pkg::LEN_TWO;
            end else if (opc[3:0] == 4'h4) begin
                d.src = citd_pkg::CITD_SRC_IMM;
                d.len = citd_pkg::LEN_TWO;
            end else begin
                d.op = citd_pkg::CITD_OP_OTHER;
            end
        end
        // relative branches on flags or accumulator: opcode plus offset byte
        if (opc == 8'h40 || opc == 8'h50 || opc == 8'h60 || opc == 8'h70) begin
            d.is_branch = 1'b1;
            d.len = citd_pkg::LEN_TWO;
        end
        return d;
    endfunction

    typedef enum logic [1:0] {
        CITD_FETCH,
        CITD_OPND,
        CITD_EXEC,
        CITD_TAKEN
    } citd_state_type;

    citd_state_type       state;
    citd_pkg::citd_dec_type cur;
    citd_pkg::citd_dec_type next_dec;
    logic [7:0]           operand;
    logic [7:0]           ram_rdata;
    logic [7:0]           ram_raddr;
    logic [7:0]           opnd_val;
    logic [8:0]           sum9;
    logic [4:0]           sum5;
    logic                 c6;
    logic                 cin;

    assign next_dec = decode(i_code_byte);

    citd_opnd_ram #(
        .DEPTH (RAM_DEPTH)
    ) u_ram (
        .i_clk_sys (i_clk_sys),
        .i_we      (i_ram_we),
        .i_waddr   (i_ram_waddr),
        .i_wdata   (i_ram_wdata),
        .i_raddr   (ram_raddr),
        .o_rdata   (ram_rdata)
    );

    // one-byte forms use the first cycle for the ram read; bank 0 registers
    // read issued from the incoming opcode so the data is ready at the next fetch
    always_comb begin
        ram_raddr = {5'h00, cur.reg_sel};
        if (state == CITD_FETCH && next_dec.src == citd_pkg::CITD_SRC_IND) begin
            ram_raddr = {7'h00, next_dec.reg_sel[0]};
        end else if (state == CITD_FETCH) begin
            ram_raddr = {5'h00, next_dec.reg_sel};
        end else if (state == CITD_OPND && cur.src == citd_pkg::CITD_SRC_DIR) begin
            ram_raddr = i_code_byte;
        end
    end

    always_comb begin
        opnd_val = ram_rdata;
        if (cur.src == citd_pkg::CITD_SRC_IMM) begin
            opnd_val = operand;
        end
    end

    // subtract as add of complement; borrow is inverted carry
    always_comb begin
        logic [7:0] b;
        b    = (cur.op == citd_pkg::CITD_OP_SUBTRACT_WITH_BORROW) ? ~opnd_val : opnd_val;
        cin  = (cur.op == citd_pkg::CITD_OP_ADD)  ? 1'b0 :
               (cur.op == citd_pkg::CITD_OP_ADD_WITH_CARRY) ? o_psw[citd_pkg::PSW_CY] : ~o_psw[citd_pkg::PSW_CY];
        sum9 = {1'b0, o_acc} + {1'b0, b} + {8'h00, cin};
        sum5 = {1'b0, o_acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        c6   = ({1'b0, o_acc[6:0]} + {1'b0, b[6:0]} + {7'h00, cin}) > 8'h7F;
    end

    // sequencer: each state is one clock; FETCH and OPND each fetch a byte, TAKEN fetches none
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            state <= CITD_FETCH;
            cur   <= '0;
        end else begin
            unique case (state)
                CITD_FETCH: begin
                    cur <= next_dec;
                    state <= (next_dec.len == citd_pkg::LEN_TWO) ? CITD_OPND : CITD_FETCH;
                end
                CITD_OPND: begin
                    // branch not taken ends here; taken needs one more clock
                    state <= (cur.is_branch && i_branch_cond) ? CITD_TAKEN : CITD_FETCH;
                end
                CITD_EXEC:  state <= CITD_FETCH;
                CITD_TAKEN: state <= CITD_FETCH;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_code_addr <= citd_pkg::PC_RESET;
        end else if (state == CITD_TAKEN) begin
            o_code_addr <= o_code_addr + {{8{operand[7]}}, operand};
        end else if (state != CITD_EXEC) begin
            o_code_addr <= o_code_addr + 16'h0001;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            operand <= 8'h00;
        end else if (state == CITD_OPND) begin
            operand <= i_code_byte;
        end
    end

    // execute flag: clock after an arithmetic instruction, during the next opcode fetch
    logic exec_one;
    logic exec_two;
    logic ex_pend;
    assign exec_one = (state == CITD_FETCH) && ex_pend && (cur.len == citd_pkg::LEN_ONE);
    assign exec_two = (state == CITD_FETCH) && ex_pend && (cur.len == citd_pkg::LEN_TWO);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            ex_pend <= 1'b0;
        end else if (state == CITD_FETCH) begin
            ex_pend <= next_dec.op != citd_pkg::CITD_OP_OTHER;
        end else begin
            ex_pend <= ex_pend;
        end
    end

    // result writes back while the next opcode is fetched (pipelined)
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_acc <= citd_pkg::ACC_RESET;
            o_psw <= citd_pkg::PSW_RESET;
        end else if (exec_one || exec_two) begin
            o_acc <= sum9[7:0];
            o_psw[citd_pkg::PSW_CY] <= (cur.op == citd_pkg::CITD_OP_SUBTRACT_WITH_BORROW) ? ~sum9[8] : sum9[8];
            o_psw[citd_pkg::PSW_AC] <= (cur.op == citd_pkg::CITD_OP_SUBTRACT_WITH_BORROW) ? ~sum5[4] : sum5[4];
            o_psw[citd_pkg::PSW_OV] <= sum9[8] ^ c6;
            o_psw[citd_pkg::PSW_P]  <= ^sum9[7:0];
        end
    end

    // an opcode fetch ends the instruction only for one-byte forms
    assign o_instr_done = (state == CITD_FETCH && next_dec.len == citd_pkg::LEN_ONE) ||
                          (state == CITD_TAKEN) ||
                          (state == CITD_OPND && !(cur.is_branch && i_branch_cond));

    a_branch_skip_time: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        state == CITD_OPND && cur.is_branch && !i_branch_cond |=> state == CITD_FETCH)
        else $error("untaken branch did not finish");
    a_branch_taken_time: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        state == CITD_OPND && cur.is_branch && i_branch_cond |=> state == CITD_TAKEN ##1 state == CITD_FETCH)
        else $error("taken branch timing wrong");
    a_two_byte_len: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_rst_b && state == CITD_FETCH && next_dec.len == citd_pkg::LEN_TWO |=> state == CITD_OPND)
        else $error("two byte instruction not two clocks");
    a_pc_advance: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        i_rst_b && state == CITD_FETCH |=> o_code_addr == $past(o_code_addr) + 16'h0001)
        else $error("program counter did not advance");
    a_imm_len_two: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        state == CITD_FETCH && i_code_byte == 8'h24 |-> next_dec.len == citd_pkg::LEN_TWO)
        else $error("immediate add length wrong");
    a_reg_len_one: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        state == CITD_FETCH && i_code_byte[7:3] == 5'h13 |-> next_dec.len == citd_pkg::LEN_ONE)
        else $error("register subtract length wrong");
    a_dir_add_with_carry_len: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        state == CITD_FETCH && i_code_byte == 8'h35 |-> next_dec.len == citd_pkg::LEN_TWO)
        else $error("direct add with carry length wrong");
    a_parity_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        exec_one |=> o_psw[citd_pkg::PSW_P] == ^o_acc)
        else $error("parity flag wrong");
    a_clock_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        state == CITD_FETCH && next_dec.len == citd_pkg::LEN_ONE && !next_dec.is_branch |=> state == CITD_FETCH)
        else $error("one byte instruction took extra clock");
endmodule // citd_core
`default_nettype wire

// [verif/citd_prog_mem.sv]
// program memory model answering the core's fetch address in the same cycle
`timescale 1ns/10ps
`default_nettype none
module citd_prog_mem (
    input  wire logic [15:0] i_code_addr,
    output var  logic [7:0]  o_code_byte
);
    // loaded by the bench; unloaded places hold the one-byte no-op
    logic [7:0] mem [0:255];

    // combinational read, as the core expects the byte in the fetch cycle
    always_comb begin
        o_code_byte = mem[i_code_addr[7:0]];
    end
endmodule // citd_prog_mem
`default_nettype wire

// [verif/tb.sv]
// self-checking bench of the arithmetic decoder and timing sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin fail_count++; \
    $display("FAIL t=%0t got %0h want %0h", $time, act, exp); end end
module tb;
    logic        clk;
    logic        rst_b;
    logic        cond;
    logic        we;
    logic [7:0]  waddr;
    logic [7:0]  wdata;
    logic [7:0]  code_byte;
    logic [15:0] code_addr;
    logic [7:0]  acc;
    logic [7:0]  program_status_word;
    logic        done;
    int          fail_count = 0;
    int          cmp_count = 0;

    citd_core citd_core_inst (
        .i_clk_sys     (clk),
        .i_rst_b       (rst_b),
        .i_code_byte   (code_byte),
        .i_branch_cond (cond),
        .i_ram_we      (we),
        .i_ram_waddr   (waddr),
        .i_ram_wdata   (wdata),
        .o_code_addr   (code_addr),
        .o_acc         (acc),
        .o_psw         (program_status_word),
        .o_instr_done  (done)
    );

    citd_prog_mem citd_prog_mem_inst (
        .i_code_addr (code_addr),
        .o_code_byte (code_byte)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // loads a program, resets, then times each instruction by its done pulse
    task automatic run(input logic [7:0] prog[$], input int lens[$], input logic [15:0] last_addr,
                       input logic [7:0] acc_e, input logic [7:0] psw_e);
        int cnt;
        int k;
        int guard;
        cnt = 0;
        k = 0;
        guard = 0;
        for (int i = 0; i < 256; i++) citd_prog_mem_inst.mem[i] = (i < prog.size()) ? prog[i] : 8'h00;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        `CHK(code_addr, 16'h0000)
        // a stuck sequencer must not hang the run
        while (k < lens.size() && guard < 200) begin
            cnt++;
            guard++;
            if (done === 1'b1) begin
                `CHK(cnt, lens[k])
                if (k == lens.size() - 1) `CHK(code_addr, last_addr)
                k++;
                cnt = 0;
            end
            @(negedge clk);
        end
        if (guard >= 200) begin
            fail_count++;
            $display("FAIL t=%0t no instruction end seen", $time);
            return;
        end
        repeat (4) @(negedge clk);
        `CHK(acc, acc_e)
        `CHK(program_status_word, psw_e)
    endtask

    task automatic ram_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        we <= 1'b1;
        waddr <= a;
        wdata <= d;
    endtask

    // every add form, ending in carry and half carry
    task automatic t_add_forms;
        run({8'h24, 8'h11, 8'h2A, 8'h25, 8'h40, 8'h27, 8'h24, 8'hE9},
            {2, 1, 2, 1, 2}, 16'h0007, 8'h20, 8'hC1);
        $display("test add_forms done");
    endtask

    // carry chained into add_with_carry, borrow into subtract, overflow last
    task automatic t_carry_borrow;
        run({8'h24, 8'hF0, 8'h24, 8'h20, 8'h3B, 8'h35, 8'h40, 8'h37, 8'h34, 8'hCB,
             8'h94, 8'h01, 8'h9A, 8'h95, 8'h40, 8'h97, 8'h94, 8'h60},
            {2, 2, 1, 2, 1, 2, 2, 1, 2, 1, 2}, 16'h0011, 8'h77, 8'h04);
        $display("test carry_borrow done");
    endtask

    // each branch opcode both ways; taken skips to offset past the next address
    task automatic t_branch;
        logic [7:0] ops[4];
        ops = '{8'h40, 8'h50, 8'h60, 8'h70};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cond <= 1'b0;
            run({ops[i], 8'h03, 8'h24, 8'h11, 8'h00, 8'h24, 8'h22},
                {2, 2, 1, 2}, 16'h0006, 8'h33, 8'h00);
            @(posedge clk);
            cond <= 1'b1;
            run({ops[i], 8'h03, 8'h24, 8'h11, 8'h00, 8'h24, 8'h22},
                {3, 2}, 16'h0006, 8'h22, 8'h00);
        end
        @(posedge clk);
        cond <= 1'b0;
        $display("test branch done");
    endtask

    initial begin
        rst_b = 1'b0;
        cond = 1'b0;
        we = 1'b0;
        waddr = 8'h00;
        wdata = 8'h00;
        // operand bytes; pointer and its target agree so either indirect reading works
        ram_wr(8'h01, 8'h01);
        ram_wr(8'h02, 8'h05);
        ram_wr(8'h03, 8'h03);
        ram_wr(8'h40, 8'h20);
        @(posedge clk);
        we <= 1'b0;
        t_add_forms();
        t_carry_borrow();
        t_branch();
        results();
    end
endmodule // tb
`default_nettype wire
